// >>> core/ext_bus_map.svh
// Purpose: Offsets, field positions, reset values and counts for the
//          external memory access block.
// Assumes: Included by bare name from the core files.
// Notes:   Definitions only.
`ifndef EXT_BUS_MAP_SVH
`define EXT_BUS_MAP_SVH

// ==========================================================
// Register map (word index, byte address is index times 4)
`define TIMING_IDX 10'h08E
`define STATUS_IDX 10'h090
`define TIMING_RESET 8'h01
`define STRETCH_MSB 2
`define STRETCH_LSB 0
`define STAT_BUSY_BIT 0
`define STAT_MOVE_BIT 1
`define STAT_STR_LSB 4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ==========================================================
// Machine cycle and strobe timing in clocks
`define PHASE_ADDR 2'h0
`define PHASE_LAST 2'h3
`define S0_FIRST 6'h05
`define S0_LAST 6'h06
`define S0_WIDTH 6'h02
`define SX_FIRST 6'h04

`endif

// >>> core/ext_bus_pkg.sv
// Purpose: Types shared by the external memory access block.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Constants live in ext_bus_map.svh.
`default_nettype none

package ext_bus_pkg;
  // ==========================================================
  // Access sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_MOVE = 2'b10
  } access_state_type;
endpackage : ext_bus_pkg

`default_nettype wire

// >>> core/mc_phase.sv
// Purpose: Free running machine cycle phase counter, four clocks a cycle.
// Assumes: Single clock, synchronous active low reset.
// Notes:   Phase 0 is the address latch clock of every machine cycle.
`default_nettype none

module mc_phase (
  input wire logic aclk,
  input wire logic aresetn,
  output logic [1:0] phase
);
  import ext_bus_pkg::*;
  `include "ext_bus_map.svh"

  logic [1:0] next_phase; // Following phase

  // ==========================================================
  // Phase counter
  // Wraps naturally after phase 3
  always_comb begin
    next_phase = phase + 2'h1;
  end

  // Register phase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= 2'h0;
    end else begin
      phase <= next_phase;
    end
  end

  // ==========================================================
  // Checks
  a_phase_wrap: assert property (
    @(posedge aclk) disable iff (!aresetn)
    phase == `PHASE_LAST |=> phase == `PHASE_ADDR ##3 phase == `PHASE_LAST)
    else $error("machine cycle is not four clocks");
endmodule : mc_phase

`default_nettype wire

// >>> core/axil_regs.sv
// Purpose: AXI4-Lite slave holding the memory timing control register.
// Assumes: One write and one read outstanding at most.
// Notes:   Unmapped addresses answer SLVERR and read as zero.
`default_nettype none

module axil_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [7:0] status_word,
  output logic [7:0] timing
);
  import ext_bus_pkg::*;
  `include "ext_bus_map.svh"

  logic aw_held, next_aw_held; // Address taken, waiting for data
  logic w_held, next_w_held; // Data taken, waiting for address
  logic [9:0] aw_idx, next_aw_idx; // Held write word index
  logic [7:0] w_byte, next_w_byte; // Held low data byte
  logic w_lane, next_w_lane; // Held strobe of byte 0
  logic commit; // Both halves present
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [7:0] next_timing;

  // ==========================================================
  // Write and read channels
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_idx = aw_idx;
    next_w_byte = w_byte;
    next_w_lane = w_lane;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_timing = timing;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    commit = aw_held && w_held && !bvalid;
    // Response taken
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    // Address and data are taken in either order
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_idx = awaddr[11:2];
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_byte = wdata[7:0];
      next_w_lane = wstrb[0];
    end
    // Commit once both halves are held
    if (commit) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `RESP_OKAY;
      if (aw_idx == `TIMING_IDX) begin
        if (w_lane) begin
          next_timing = w_byte;
        end
      end else if (aw_idx != `STATUS_IDX) begin
        next_bresp = `RESP_SLVERR;
      end
    end
    // Read side
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = `RESP_OKAY;
      next_rdata = 32'h0000_0000;
      if (araddr[11:2] == `TIMING_IDX) begin
        next_rdata[7:0] = timing;
      end else if (araddr[11:2] == `STATUS_IDX) begin
        next_rdata[7:0] = status_word;
      end else begin
        next_rresp = `RESP_SLVERR;
      end
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
    next_arready = !next_rvalid;
  end

  // Register channel state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 10'h000;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'h0;
      timing <= `TIMING_RESET;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_idx <= next_aw_idx;
      w_byte <= next_w_byte;
      w_lane <= next_w_lane;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      timing <= next_timing;
    end
  end

  // ==========================================================
  // Checks
  a_timing_write: assert property (
    @(posedge aclk) disable iff (!aresetn)
    commit && aw_idx == `TIMING_IDX && w_lane
    |=> timing == $past(w_byte) && bvalid)
    else $error("timing register write lost");
endmodule : axil_regs

`default_nettype wire

// >>> core/ext_mem_access.sv
// Purpose: External program fetch and stretched data move sequencer
//          driving a multiplexed address/data port and high address port.
// Assumes: One clock; requests are levels held until their done pulse.
// Notes:   Pins are registered; pin state in a clock is decoded from the
//          sequencer position of that clock.
`default_nettype none

// Behaviour
// - Machine cycle is four clocks
// - All code is fetched from external memory
// - Low address muxed with data, high separate
// - Fetch timing fixed by clock only
// - Stretch selectable from 0 to 7
// - Stretch in timing register bits 2..0
// - Move lasts stretch plus two machine cycles
// - Stretch zero move takes two cycles
// - Stretch resets to one
// - New stretch applies to later moves
// - Stretch widens strobe and bus phases
// - Strobe 2 clocks, else four times stretch
// - Stretch never slows program fetch
// - One address latch pulse per machine cycle
module ext_mem_access (
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Core side program fetch
  input wire logic code_req,
  input wire logic [15:0] code_addr,
  output logic code_done,
  output logic [7:0] code_data,
  // Core side external data move
  input wire logic data_req,
  input wire logic data_we,
  input wire logic [15:0] data_addr,
  input wire logic [7:0] data_wdata,
  output logic data_done,
  output logic [7:0] data_rdata,
  // External bus pins
  output logic ale,
  output logic psen_n,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] muxed_addr_data_port_out,
  output logic muxed_addr_data_port_oe,
  input wire logic [7:0] muxed_addr_data_port_in,
  output logic [7:0] upper_address_port
);
  import ext_bus_pkg::*;
  `include "ext_bus_map.svh"

  // ==========================================================
  // Declarations
  logic [1:0] phase; // Position inside machine cycle
  logic [1:0] next_phase; // Phase of the following clock
  logic [7:0] timing; // Memory timing control register
  logic [2:0] stretch; // Live stretch field
  logic [7:0] status_word; // Sequencer state for software
  access_state_type state, next_state; // Sequencer state
  logic [3:0] mc, next_mc; // Machine cycle inside access
  logic [15:0] addr, next_addr; // Latched access address
  logic we, next_we; // Latched write flag
  logic [7:0] wbyte, next_wbyte; // Latched write byte
  logic [2:0] mstretch, next_mstretch; // Stretch of current move
  logic [5:0] t; // Clock inside access
  logic [5:0] nt; // Clock inside access, next
  logic next_code_done, next_data_done;
  logic [7:0] next_code_data, next_data_rdata;
  logic next_ale, next_psen_n, next_rd_n, next_wr_n;
  logic [7:0] next_p0_out, next_p2;
  logic next_p0_oe;
  logic [5:0] strobe_len; // Helper: low clocks of strobe
  logic [5:0] move_len; // Helper: clocks spent in a move

  // ==========================================================
  // Timing helpers
  // First strobe clock of a move
  function automatic logic [5:0] strobe_first(input logic [2:0] s);
    strobe_first = (s == 3'h0) ? `S0_FIRST : `SX_FIRST;
  endfunction : strobe_first

  // Last strobe clock: 6 at zero, else 4*s+3
  function automatic logic [5:0] strobe_last(input logic [2:0] s);
    strobe_last = (s == 3'h0) ? `S0_LAST : {1'b0, s, 2'b11};
  endfunction : strobe_last

  // Last clock of a move: 4*(s+2)-1
  function automatic logic [5:0] move_last(input logic [2:0] s);
    move_last = {({1'b0, s} + 4'h1), 2'b11};
  endfunction : move_last

  // ==========================================================
  // Submodules
  // Machine cycle phase source
  mc_phase u_phase (
    .aclk(aclk),
    .aresetn(aresetn),
    .phase(phase)
  );

  // Register slave
  axil_regs u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .status_word(status_word),
    .timing(timing)
  );

  // Stretch field and status view
  assign stretch = timing[`STRETCH_MSB:`STRETCH_LSB];
  always_comb begin
    status_word = 8'h00;
    status_word[`STAT_BUSY_BIT] = (state != ST_IDLE);
    status_word[`STAT_MOVE_BIT] = (state == ST_MOVE);
    status_word[`STAT_STR_LSB +: 3] = mstretch;
  end

  // ==========================================================
  // Sequencer
  // Accepts work only at the end of a machine cycle
  always_comb begin
    next_state = state;
    next_mc = mc;
    next_addr = addr;
    next_we = we;
    next_wbyte = wbyte;
    next_mstretch = mstretch;
    next_code_done = 1'b0;
    next_data_done = 1'b0;
    next_code_data = code_data;
    next_data_rdata = data_rdata;
    t = {mc, phase};
    unique case (state)
      ST_IDLE: begin
        if (phase == `PHASE_LAST) begin
          // Fetch first; a move waits its turn
          if (code_req) begin
            next_state = ST_FETCH;
            next_addr = code_addr;
            next_mc = 4'h0;
          end else if (data_req) begin
            next_state = ST_MOVE;
            next_addr = data_addr;
            next_we = data_we;
            next_wbyte = data_wdata;
            next_mstretch = stretch;
            next_mc = 4'h0;
          end
        end
      end
      ST_FETCH: begin
        // One machine cycle, stretch never consulted
        if (phase == `PHASE_LAST) begin
          next_code_data = muxed_addr_data_port_in;
          next_code_done = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_MOVE: begin
        // Advance machine cycle count
        if (phase == `PHASE_LAST) begin
          next_mc = mc + 4'h1;
        end
        // Sample read data on the last strobe clock
        if (!we && t == strobe_last(mstretch)) begin
          next_data_rdata = muxed_addr_data_port_in;
        end
        // Move ends after stretch plus two machine cycles
        if (t == move_last(mstretch)) begin
          next_data_done = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: begin
        // Illegal code recovers to idle
        next_state = ST_IDLE;
      end
    endcase
  end

  // Register sequencer state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      mc <= 4'h0;
      addr <= 16'h0000;
      we <= 1'b0;
      wbyte <= 8'h00;
      mstretch <= 3'h1;
      code_done <= 1'b0;
      data_done <= 1'b0;
      code_data <= 8'h00;
      data_rdata <= 8'h00;
    end else begin
      state <= next_state;
      mc <= next_mc;
      addr <= next_addr;
      we <= next_we;
      wbyte <= next_wbyte;
      mstretch <= next_mstretch;
      code_done <= next_code_done;
      data_done <= next_data_done;
      code_data <= next_code_data;
      data_rdata <= next_data_rdata;
    end
  end

  // ==========================================================
  // Pin decode
  // Decoded from the next position so pins line up with it
  always_comb begin
    next_phase = phase + 2'h1;
    nt = {next_mc, next_phase};
    next_ale = (next_phase == `PHASE_ADDR);
    next_psen_n = 1'b1;
    next_rd_n = 1'b1;
    next_wr_n = 1'b1;
    next_p0_out = next_addr[7:0];
    next_p0_oe = 1'b0;
    next_p2 = upper_address_port;
    unique case (next_state)
      ST_IDLE: begin
        // Bus released, high address held
        next_p0_oe = 1'b0;
      end
      ST_FETCH: begin
        // Address in clock 0, code strobe in clocks 1..3
        next_p2 = next_addr[15:8];
        next_p0_oe = (nt == 6'h00);
        next_psen_n = (nt == 6'h00);
      end
      ST_MOVE: begin
        // Address in clock 0, strobe spans stretched window
        next_p2 = next_addr[15:8];
        if (nt == 6'h00) begin
          next_p0_oe = 1'b1;
        end else if (nt >= strobe_first(next_mstretch) &&
                     nt <= strobe_last(next_mstretch)) begin
          next_rd_n = next_we;
          next_wr_n = !next_we;
          next_p0_out = next_wbyte;
          next_p0_oe = next_we;
        end else if (next_we && nt >= strobe_first(next_mstretch) &&
                     nt <= strobe_last(next_mstretch) + 6'h01) begin
          // Hold write data one clock past the strobe
          next_p0_out = next_wbyte;
          next_p0_oe = 1'b1;
        end
      end
      default: begin
        next_p0_oe = 1'b0;
      end
    endcase
  end

  // Register pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ale <= 1'b1;
      psen_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      muxed_addr_data_port_out <= 8'h00;
      muxed_addr_data_port_oe <= 1'b0;
      upper_address_port <= 8'h00;
    end else begin
      ale <= next_ale;
      psen_n <= next_psen_n;
      rd_n <= next_rd_n;
      wr_n <= next_wr_n;
      muxed_addr_data_port_out <= next_p0_out;
      muxed_addr_data_port_oe <= next_p0_oe;
      upper_address_port <= next_p2;
    end
  end

  // ==========================================================
  // Check helpers
  // Strobe low count and move length count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_len <= 6'h00;
      move_len <= 6'h00;
    end else begin
      strobe_len <= (rd_n && wr_n) ? 6'h00 : strobe_len + 6'h01;
      move_len <= (state == ST_MOVE) ? move_len + 6'h01 : 6'h00;
    end
  end

  // ==========================================================
  // Checks
  a_ale_every_cycle: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ale |=> !ale [*3] ##1 ale)
    else $error("latch pulse not once per machine cycle");

  a_strobe_width: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(rd_n && wr_n) |-> strobe_len ==
      ((mstretch == 3'h0) ? `S0_WIDTH : {1'b0, mstretch, 2'b00}))
    else $error("data strobe width wrong for stretch");

  a_move_length: assert property (
    @(posedge aclk) disable iff (!aresetn)
    data_done |-> move_len == {({1'b0, mstretch} + 4'h2), 2'b00})
    else $error("data move length wrong for stretch");

  a_fetch_fixed: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $fell(psen_n) |-> $past(ale) ##0 !psen_n [*3] ##1 psen_n)
    else $error("program fetch strobe not three clocks");

  a_fetch_no_data: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !psen_n |-> rd_n && wr_n && !muxed_addr_data_port_oe)
    else $error("data strobe during program fetch");

  a_write_drives: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !wr_n |-> muxed_addr_data_port_oe &&
      muxed_addr_data_port_out == wbyte)
    else $error("write strobe without data on port");

  a_reset_stretch: assert property (
    @(posedge aclk)
    !aresetn |=> stretch == 3'h1)
    else $error("stretch not one after reset");

  a_move_fast: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(state == ST_MOVE) && mstretch == 3'h0 |-> ##8 data_done)
    else $error("stretch zero move not two cycles");
endmodule : ext_mem_access

`default_nettype wire

// >>> bench/ext_mem_model.sv
// Purpose: External memory with address latch on the access block pins.
// Assumes: One clock; low address is latched while ale is high.
// Notes:   A released port shows a pattern that changes every clock.
`default_nettype none

module ext_mem_model (
  input wire logic aclk,
  input wire logic ale,
  input wire logic psen_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] out_byte,
  input wire logic out_en,
  input wire logic [7:0] upper,
  input wire logic [31:0] access_ns,
  output logic [7:0] port
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:65535]; // Storage
  logic [15:0] latched = 16'h0000; // Latched address
  logic [7:0] idle = 8'h5A; // Released pattern
  logic ready = 1'b0; // Read data valid
  // ==========
  // Latch between strobes, store on the write strobe
  always @(posedge aclk) begin
    if (ale && out_en && psen_n && rd_n && wr_n) begin
      latched <= {upper, port};
    end
    if (!wr_n) begin
      mem[latched] <= port;
    end
    idle <= ~port;
  end
  // ==========
  // Data turns valid some time after the strobe falls
  always @(negedge rd_n or negedge psen_n) begin
    ready = 1'b0;
    ready <= #(rd_n ? 20 : access_ns) 1'b1;
  end
  assign port = out_en ? out_byte : (rd_n && psen_n) ? idle :
    ready ? mem[latched] : ~mem[latched];
endmodule : ext_mem_model

`default_nettype wire

// >>> bench/test_stretched_external_data_access.sv
// Purpose: Self-checking bench for the stretched external access block.
// Assumes: Memory model on the pins; register bus answers in 50 clocks.
// Notes:   Drivers queue expected results; one monitor checks them.
`include "ext_bus_map.svh"
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module test_stretched_external_data_access;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [11:0] TIMING_ADDR = {`TIMING_IDX, 2'b00};
  // ==========
  // Design signals
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, code_req = 1'b0;
  logic data_req = 1'b0, data_we = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, access_ns = 32'h1E;
  logic [3:0] wstrb = 4'hF;
  logic [15:0] code_addr = 16'h0, data_addr = 16'h0;
  logic [7:0] data_wdata = 8'h00;
  logic awready, wready, bvalid, arready, rvalid, code_done, data_done;
  logic ale, psen_n, rd_n, wr_n, muxed_addr_data_port_oe;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] code_data, data_rdata, muxed_addr_data_port_out;
  logic [7:0] muxed_addr_data_port_in, upper_address_port;
  // Checking state
  logic [31:0] expq[$];
  logic [31:0] got, exp_v;
  int fails = 0, n_compared = 0, cyc = 1, live = 0, last_ale = 0;
  int start = 0, width = 0;
  bit inflight = 1'b0;

  ext_mem_access dut_u (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .code_req, .code_addr, .code_done, .code_data,
    .data_req, .data_we, .data_addr, .data_wdata, .data_done, .data_rdata,
    .ale, .psen_n, .rd_n, .wr_n, .muxed_addr_data_port_out,
    .muxed_addr_data_port_oe, .muxed_addr_data_port_in, .upper_address_port
  );
  ext_mem_model mem_u (
    .aclk, .ale, .psen_n, .rd_n, .wr_n, .out_byte(muxed_addr_data_port_out),
    .out_en(muxed_addr_data_port_oe), .upper(upper_address_port),
    .access_ns, .port(muxed_addr_data_port_in)
  );

  always #12.5 aclk = ~aclk;

  // ==========
  // Monitor: latch pulse spacing and queued results
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    live <= aresetn ? live + 1 : 0;
    if (!aresetn) last_ale <= 0;
    if (ale && live > 2) begin
      if (last_ale > 0) `CHK(cyc - last_ale, 4)
      last_ale <= cyc;
    end
    if (inflight && (!rd_n || !wr_n)) width <= width + 1;
    if (code_done || data_done) begin
      got = {8'(cyc - start), 8'(width), 16'h0000};
      got[15:8] = code_done ? code_data : data_we ? 8'h00 : data_rdata;
      exp_v = expq.pop_front();
      `CHK(got, exp_v)
      inflight <= 1'b0;
    end
    if (ale && muxed_addr_data_port_oe &&
        (!inflight || code_done || data_done)) begin
      // Address phase shows the requested address on both ports
      got = {16'h0000, upper_address_port, muxed_addr_data_port_out};
      exp_v = {16'h0000, code_req ? code_addr : data_addr};
      `CHK(got, exp_v)
      start <= cyc;
      width <= 0;
      inflight <= 1'b1;
    end
    if (bvalid && bready) begin
      exp_v = expq.pop_front();
      `CHK({30'h0, bresp}, exp_v)
    end
    if (rvalid && rready) begin
      exp_v = expq.pop_front();
      `CHK({rresp, rdata[29:0]}, exp_v)
    end
  end

  // ==========
  // Drivers
  function automatic logic [31:0] mv(input logic [2:0] s,
      input logic [7:0] d);
    return {8'(4 * (s + 2)), 8'(s == 0 ? 2 : 4 * s), d, 8'h00};
  endfunction : mv

  task automatic end_of_test();
    if (expq.size() != 0) fails++;
    if (fails == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task automatic reg_op(input bit we, input logic [11:0] a,
      input logic [31:0] d, input logic [31:0] e);
    int i;
    i = 0;
    expq.push_back(e);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= we;
    wvalid <= we;
    bready <= we;
    arvalid <= !we;
    rready <= !we;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) bready <= 1'b0;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) rready <= 1'b0;
      i++;
    end while (i < 50 && (awvalid || wvalid || bready || arvalid || rready));
    if (i >= 50) begin
      fails++;
      end_of_test();
    end
  endtask : reg_op

  task automatic mem_op(input logic [1:0] k, input logic [15:0] a,
      input logic [7:0] d, input logic [31:0] e);
    int i;
    i = 0;
    expq.push_back(e);
    code_req <= k == 2'h0;
    data_req <= k != 2'h0;
    data_we <= k == 2'h2;
    code_addr <= a;
    data_addr <= a;
    data_wdata <= d;
    do begin
      @(posedge aclk);
      i++;
    end while (i < 100 && !(code_done || data_done));
    if (i >= 100) begin
      fails++;
      end_of_test();
    end
  endtask : mem_op

  task automatic idle_core();
    code_req <= 1'b0;
    data_req <= 1'b0;
    @(posedge aclk);
  endtask : idle_core

  // ==========
  // Main sequence
  initial begin
    logic [15:0] a, prev;
    logic [7:0] d, rv, pd;
    void'($urandom(32'h9BF7));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    reg_op(1'b0, TIMING_ADDR, 32'h0, {24'h0, `TIMING_RESET});
    prev = {8'hF0, 8'($urandom)};
    d = 8'($urandom);
    pd = d;
    mem_op(2'h2, prev, d, mv(3'h1, 8'h00));
    mem_op(2'h1, prev, 8'h00, mv(3'h1, d));
    idle_core();
    for (int s = 0; s < 8; s++) begin
      rv = {5'($urandom), 3'(s)};
      reg_op(1'b1, TIMING_ADDR, {24'($urandom), rv}, 32'h0);
      reg_op(1'b0, TIMING_ADDR, 32'h0, {24'h0, rv});
      access_ns <= (s == 0) ? 32'h1E : 100 * s - 20;
      a = {8'(s), 8'($urandom)};
      d = 8'($urandom);
      mem_op(2'h2, a, d, mv(3'(s), 8'h00));
      mem_op(2'h1, a, 8'h00, mv(3'(s), d));
      mem_op(2'h0, a, 8'h00, {16'h0400, d, 8'h00});
      mem_op(2'h0, prev, 8'h00, {16'h0400, pd, 8'h00});
      prev = a;
      pd = d;
      idle_core();
    end
    reg_op(1'b1, 12'h100, 32'hFF, {30'h0, `RESP_SLVERR});
    reg_op(1'b0, 12'h100, 32'h0, {`RESP_SLVERR, 30'h0});
    // Status: idle, stretch of the latest move was seven
    reg_op(1'b0, {`STATUS_IDX, 2'b00}, 32'h0, 32'h70);
    // A write without byte lane zero leaves the register alone
    wstrb <= 4'hE;
    reg_op(1'b1, TIMING_ADDR, 32'h0, 32'h0);
    reg_op(1'b0, TIMING_ADDR, 32'h0, {24'h0, rv});
    end_of_test();
  end
endmodule : test_stretched_external_data_access

`default_nettype wire
